// [common/uxcb_defs.svh]
/*
 Constants of the extended control banks: offsets, codes, thresholds, timing.
 Assumes a 10 MHz ref_clk.
*/
`ifndef UXCB_DEFS_SVH
`define UXCB_DEFS_SVH
`define UXCB_OFF_0 3'h0
`define UXCB_OFF_1 3'h1
`define UXCB_OFF_2 3'h2
`define UXCB_OFF_BANK_SEL 3'h3
`define UXCB_OFF_4 3'h4
`define UXCB_OFF_6 3'h6
`define UXCB_OFF_7 3'h7
`define UXCB_BANK_SEL_B2 8'hE0
`define UXCB_BANK_SEL_B3 8'hE4
`define UXCB_BANK_SEL_B4 8'hE8
`define UXCB_BANK_SEL_B5 8'hEC
`define UXCB_RX_THR_LO 5'h04
`define UXCB_TX_THR_LO 5'h0D
`define UXCB_RX_THR_HI 5'h0A
`define UXCB_TX_THR_HI 5'h07
`define UXCB_IR_CTL_TWO_RST 8'h02
`define UXCB_STATUS_IR_FIXED 8'h30
`define UXCB_PRE_X8_13 8'h68
`define UXCB_PRE_X8_1625 8'h0D
`define UXCB_PRE_X8_1 8'h08
`define UXCB_CLK_PERIOD_PS 100000
`define UXCB_FAIR_TIME_PS 10500000
`define UXCB_FAIR_CYC (`UXCB_FAIR_TIME_PS / `UXCB_CLK_PERIOD_PS)
`define UXCB_TOUT_TIME_PS 40000000
`define UXCB_TOUT_CYC (`UXCB_TOUT_TIME_PS / `UXCB_CLK_PERIOD_PS)
`endif

// [common/uxcb_pkg.sv]
/*
 Types of the extended control banks.
 Assumes nothing beyond the constants header.
*/
package uxcb_pkg;
  typedef enum logic [2:0] {
    UXCB_BANK0 = 3'b000,
    UXCB_BANK1 = 3'b001,
    UXCB_BANK2 = 3'b010,
    UXCB_BANK3 = 3'b011,
    UXCB_BANK4 = 3'b100,
    UXCB_BANK5 = 3'b101
  } uxcb_bank_e;
endpackage : uxcb_pkg

// [design/uxcb_top.sv]
/*
 Byte FIFO and the extended control / status banks of a serial port.
 Assumes a synchronous 8-bit register port on ref_clk, one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uxcb_defs.svh"

// Byte FIFO with level count
module uxcb_fifo #(
  parameter int W = 8,
  parameter int D = 8,
  parameter int LW = 5
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [LW-1:0] level
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  if (D < 2 || D >= (1 << LW) || (1 << AW) != D) begin : g_chk
    $error("uxcb_fifo: depth must be a power of two below 2**LW");
  end
  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [LW-1:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = (cnt_reg != LW'(D));
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rptr_reg];
  assign level = cnt_reg;
  // Storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end
  // Pointers and count
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clr) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wptr_reg <= wptr_reg + AW'(1);
      if (pop) rptr_reg <= rptr_reg + AW'(1);
      if (push && !pop) cnt_reg <= cnt_reg + LW'(1);
      else if (pop && !push) cnt_reg <= cnt_reg - LW'(1);
    end
  end
endmodule : uxcb_fifo

module uxcb_top
  import uxcb_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter logic [3:0] MODULE_TYPE = 4'h5, // Arbitrary value
  parameter logic [3:0] MODULE_REV = 4'h1 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic dma_req_a,
  output logic dma_req_b,
  input wire logic dma_ack_a,
  input wire logic dma_ack_b,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  input wire logic tx_byte_ready,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid,
  output logic rx_byte_ready,
  input wire logic tx_line,
  input wire logic ir_tx_line,
  output logic rx_line,
  input wire logic ser_rx_pin,
  input wire logic ir_rx_pin,
  output logic ser_tx_pin,
  output logic ir_tx_pin,
  input wire logic cts_pin_n,
  input wire logic dsr_pin_n,
  input wire logic ri_pin_n,
  input wire logic dcd_pin_n,
  output logic dtr_pin_n,
  output logic rts_pin_n,
  input wire logic baud_clk_out,
  input wire logic ext_ir_sel,
  output logic modem_status_evt,
  output logic [15:0] baud_divisor,
  output logic [7:0] prescale_x8,
  output logic [7:0] line_ctrl_reg
);
  uxcb_bank_e bank_reg;
  logic [7:0] fifo_ctrl_reg;
  logic [7:0] modem_control_reg;
  logic [3:0] irq_enable_reg;
  logic [7:0] extended_control_one;
  logic [7:0] extended_control_two;
  logic [7:0] infrared_control_one;
  logic [7:0] infrared_control_two;
  logic loop_reg;
  logic [15:0] div_reg;
  logic [7:0] scr_lo_reg;
  logic [7:0] scr_hi_reg;
  logic extended_select;
  logic dma_fairness_ctl;
  logic dma_threshold_sel;
  logic dma_channel_swap;
  logic tx_enable_in_wrap;
  logic baud_gen_test_out;
  logic [1:0] prescale_select_field;
  logic div_lock;
  logic ir_modem_status_sel;
  assign extended_select = extended_control_one[0];
  assign dma_fairness_ctl = extended_control_one[1];
  assign dma_threshold_sel = extended_control_one[2];
  assign dma_channel_swap = extended_control_one[3];
  assign tx_enable_in_wrap = extended_control_one[5];
  assign baud_gen_test_out = extended_control_one[7];
  assign prescale_select_field = extended_control_two[5:4];
  assign div_lock = extended_control_two[7];
  assign ir_modem_status_sel = infrared_control_two[1];

  // Address decode; a DMA acknowledge steers the strobe to the data FIFOs
  logic tx_ack;
  logic rx_ack;
  logic dma_cyc;
  logic wr;
  logic rd;
  logic acc;
  logic scratch_mode;
  logic legacy_div;
  logic fallback;
  assign tx_ack = dma_channel_swap ? dma_ack_b : dma_ack_a;
  assign rx_ack = dma_channel_swap ? dma_ack_a : dma_ack_b;
  assign dma_cyc = tx_ack | rx_ack;
  assign wr = io_wr & ~dma_cyc;
  assign rd = io_rd & ~dma_cyc;
  assign acc = wr | rd;
  assign scratch_mode = div_lock & ~extended_select;
  assign legacy_div = (bank_reg == UXCB_BANK1) && (io_addr <= `UXCB_OFF_1);
  assign fallback = acc & legacy_div & ~scratch_mode;

  // Bank select and line control; line control written from any bank
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bank_reg <= UXCB_BANK0;
      line_ctrl_reg <= 8'h00;
    end else if (wr && io_addr == `UXCB_OFF_BANK_SEL) begin
      if (!io_wdata[7] || !io_wdata[6]) begin
        line_ctrl_reg <= io_wdata;
        bank_reg <= io_wdata[7] ? UXCB_BANK1 : UXCB_BANK0;
      end else if (io_wdata == `UXCB_BANK_SEL_B2) begin
        bank_reg <= UXCB_BANK2;
      end else if (io_wdata == `UXCB_BANK_SEL_B3) begin
        bank_reg <= UXCB_BANK3;
      end else if (io_wdata == `UXCB_BANK_SEL_B4) begin
        bank_reg <= UXCB_BANK4;
      end else if (io_wdata == `UXCB_BANK_SEL_B5) begin
        bank_reg <= UXCB_BANK5;
      end
    end
  end

  // Bank-zero FIFO control and interrupt enable
  logic fifo_ctl_wr;
  assign fifo_ctl_wr = wr && bank_reg == UXCB_BANK0 && io_addr == `UXCB_OFF_2;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fifo_ctrl_reg <= 8'h00;
      irq_enable_reg <= 4'h0;
    end else begin
      if (fifo_ctl_wr) fifo_ctrl_reg <= io_wdata;
      if (wr && bank_reg == UXCB_BANK0 && io_addr == `UXCB_OFF_1) irq_enable_reg <= io_wdata[3:0];
    end
  end

  // Mode control registers, with fallback clearing on legacy divisor access
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      modem_control_reg <= 8'h00;
      extended_control_one <= 8'h00;
      extended_control_two <= 8'h00;
      infrared_control_one <= 8'h00;
      infrared_control_two <= `UXCB_IR_CTL_TWO_RST;
      loop_reg <= 1'b0;
    end else if (fallback) begin
      if (extended_select) begin
        modem_control_reg[7:2] <= 6'h00;
        loop_reg <= 1'b0;
        extended_control_one[0] <= 1'b0;
        infrared_control_one[3:2] <= 2'b00;
      end
      extended_control_one[5] <= 1'b0;
      extended_control_one[7] <= 1'b0;
      extended_control_two[5:0] <= 6'h00;
    end else if (wr) begin
      unique case (bank_reg)
        UXCB_BANK0: begin
          if (io_addr == `UXCB_OFF_4) begin
            modem_control_reg <= {io_wdata[7:5], 1'b0, io_wdata[3:0]};
            if (!extended_select) loop_reg <= io_wdata[4];
          end
        end
        UXCB_BANK2: begin
          if (io_addr == `UXCB_OFF_2) begin
            extended_control_one <= {io_wdata[7:5], 1'b0, io_wdata[3:0]};
            loop_reg <= io_wdata[4];
          end
          if (io_addr == `UXCB_OFF_4) extended_control_two <= {io_wdata[7], 1'b0, io_wdata[5:4], 4'h0};
        end
        UXCB_BANK4: begin
          if (io_addr == `UXCB_OFF_2) infrared_control_one <= {4'h0, io_wdata[3:2], 2'b00};
        end
        UXCB_BANK5: begin
          if (io_addr == `UXCB_OFF_4) infrared_control_two <= {3'h0, io_wdata[4], 2'b00, io_wdata[1:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // Divisor latch and the scratchpads overlaid on it in bank one while locked with extended select clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_reg <= 16'h0001;
      scr_lo_reg <= 8'h00;
      scr_hi_reg <= 8'h00;
    end else if (wr && io_addr <= `UXCB_OFF_1) begin
      if (bank_reg == UXCB_BANK1 && scratch_mode) begin
        if (io_addr[0]) scr_hi_reg <= io_wdata;
        else scr_lo_reg <= io_wdata;
      end else if (bank_reg == UXCB_BANK1 || bank_reg == UXCB_BANK2) begin
        if (io_addr[0]) div_reg[15:8] <= io_wdata;
        else div_reg[7:0] <= io_wdata;
      end
    end
  end
  assign baud_divisor = div_reg;

  // Prescaler ratio in eighths toward the baud generator
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prescale_x8 <= `UXCB_PRE_X8_13;
    end else begin
      unique case (prescale_select_field)
        2'b00: prescale_x8 <= `UXCB_PRE_X8_13;
        2'b01: prescale_x8 <= `UXCB_PRE_X8_1625;
        2'b11: prescale_x8 <= `UXCB_PRE_X8_1;
        2'b10: prescale_x8 <= prescale_x8; // Reserved code keeps the last ratio
      endcase
    end
  end

  // Transmit and receive FIFOs
  logic [4:0] tx_level;
  logic [4:0] rx_level;
  logic [7:0] rx_head;
  logic tx_push;
  logic rx_pop;
  logic tx_full;
  logic rx_empty;
  logic rx_in_ready;
  logic tx_in_ready;
  logic rx_head_valid;
  assign tx_push = (io_wr & tx_ack) | (wr && bank_reg == UXCB_BANK0 && io_addr == `UXCB_OFF_0);
  assign rx_pop = (io_rd & rx_ack) | (rd && bank_reg == UXCB_BANK0 && io_addr == `UXCB_OFF_0);
  assign tx_full = ~tx_in_ready;
  assign rx_empty = ~rx_head_valid;
  assign rx_byte_ready = rx_in_ready;
  uxcb_fifo #(.W(8), .D(FIFO_DEPTH), .LW(5)) u_tx_fifo (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clr(fifo_ctl_wr & io_wdata[2]),
    .in_data(io_wdata), .in_valid(tx_push), .in_ready(tx_in_ready),
    .out_data(tx_byte), .out_valid(tx_byte_valid), .out_ready(tx_byte_ready),
    .level(tx_level)
  );
  uxcb_fifo #(.W(8), .D(FIFO_DEPTH), .LW(5)) u_rx_fifo (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clr(fifo_ctl_wr & io_wdata[1]),
    .in_data(rx_byte), .in_valid(rx_byte_valid), .in_ready(rx_in_ready),
    .out_data(rx_head), .out_valid(rx_head_valid), .out_ready(rx_pop),
    .level(rx_level)
  );

  // Receive timeout: idle interval with data waiting below threshold
  localparam int TOUT_CYC = `UXCB_TOUT_CYC;
  logic [8:0] tout_cnt_reg;
  logic tout_reg;
  logic [4:0] rx_thr;
  logic [4:0] tx_thr;
  assign rx_thr = dma_threshold_sel ? `UXCB_RX_THR_HI : `UXCB_RX_THR_LO;
  assign tx_thr = dma_threshold_sel ? `UXCB_TX_THR_HI : `UXCB_TX_THR_LO;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || rx_byte_valid || rx_empty || rx_level >= rx_thr) begin
      tout_cnt_reg <= 9'h000;
      tout_reg <= 1'b0;
    end else if (tout_cnt_reg == 9'(TOUT_CYC - 1)) begin
      tout_reg <= 1'b1;
    end else begin
      tout_cnt_reg <= tout_cnt_reg + 9'h001;
    end
  end

  // DMA requests with burst limit or full/empty hold
  localparam int FAIR_CYC = `UXCB_FAIR_CYC;
  logic tx_req_reg;
  logic rx_req_reg;
  logic tx_req_next;
  logic rx_req_next;
  logic [7:0] burst_cnt_reg;
  logic burst_end;
  logic tx_raise;
  logic rx_raise;
  assign tx_raise = tx_level < tx_thr;
  assign rx_raise = (rx_level >= rx_thr) | tout_reg;
  assign burst_end = ~dma_fairness_ctl && burst_cnt_reg == 8'(FAIR_CYC - 1);
  always_comb begin
    if (dma_fairness_ctl) begin
      tx_req_next = (tx_raise | tx_req_reg) & ~tx_full;
      rx_req_next = (rx_raise | rx_req_reg) & ~rx_empty;
    end else begin
      tx_req_next = tx_raise & ~tx_full & ~burst_end;
      rx_req_next = rx_raise & ~rx_empty & ~burst_end;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_req_reg <= 1'b0;
      rx_req_reg <= 1'b0;
      burst_cnt_reg <= 8'h00;
    end else begin
      tx_req_reg <= tx_req_next;
      rx_req_reg <= rx_req_next;
      // Burst length only counts while the fairness limit is in force
      if (burst_end || dma_fairness_ctl || !(tx_req_reg || rx_req_reg)) burst_cnt_reg <= 8'h00;
      else burst_cnt_reg <= burst_cnt_reg + 8'h01;
    end
  end
  assign dma_req_a = dma_channel_swap ? rx_req_reg : tx_req_reg;
  assign dma_req_b = dma_channel_swap ? tx_req_reg : rx_req_reg;

  // Pin synchronisers: three stages, a change counts when stages two and three agree
  logic [5:0] sy1_reg;
  logic [5:0] sy2_reg;
  logic [5:0] sy3_reg;
  logic [5:0] pin_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sy1_reg <= 6'h3F;
      sy2_reg <= 6'h3F;
      sy3_reg <= 6'h3F;
      pin_reg <= 6'h3F;
    end else begin
      sy1_reg <= {ir_rx_pin, ser_rx_pin, dcd_pin_n, ri_pin_n, dsr_pin_n, cts_pin_n};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
      pin_reg <= (sy2_reg & sy3_reg) | (pin_reg & (sy2_reg ^ sy3_reg));
    end
  end

  // Internal modem status {dcd, ri, dsr, cts}, pins cut off in loopback
  logic [3:0] ms_next;
  logic [3:0] ms_reg;
  logic ir_active;
  logic ms_block;
  assign ir_active = extended_select ? ext_ir_sel : infrared_control_one[3];
  assign ms_block = ir_active & ir_modem_status_sel;
  always_comb begin
    if (!loop_reg) ms_next = ~pin_reg[3:0];
    else if (extended_select) ms_next = {modem_control_reg[1], modem_control_reg[0],
                                          modem_control_reg[0], modem_control_reg[1]};
    else ms_next = {modem_control_reg[3], modem_control_reg[2],
                    modem_control_reg[0], modem_control_reg[1]};
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ms_reg <= 4'h0;
      modem_status_evt <= 1'b0;
    end else begin
      ms_reg <= ms_next;
      modem_status_evt <= (ms_next != ms_reg) & irq_enable_reg[3] & ~ms_block;
    end
  end

  // Serial lines: wrap in loopback, outputs idle unless enabled
  logic wrap_idle;
  assign wrap_idle = loop_reg & ~tx_enable_in_wrap;
  assign rx_line = loop_reg ? (ir_active ? ir_tx_line : tx_line)
                 : (ir_active ? pin_reg[5] : pin_reg[4]);
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ser_tx_pin <= 1'b1;
      ir_tx_pin <= 1'b0;
      rts_pin_n <= 1'b1;
    end else begin
      ser_tx_pin <= wrap_idle | tx_line;
      ir_tx_pin <= ~wrap_idle & ir_tx_line;
      rts_pin_n <= ~modem_control_reg[1];
    end
  end
  assign dtr_pin_n = baud_gen_test_out ? baud_clk_out : ~modem_control_reg[0];

  // Read mux; a read of bank-zero data pops the receive FIFO
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (io_rd && rx_ack) begin
      rd_val = rx_head;
    end else if (io_addr == `UXCB_OFF_BANK_SEL) begin
      rd_val = line_ctrl_reg;
    end else begin
      unique case (bank_reg)
        UXCB_BANK0: begin
          if (io_addr == `UXCB_OFF_0) rd_val = rx_head;
          if (io_addr == `UXCB_OFF_1) rd_val = {4'h0, irq_enable_reg};
          if (io_addr == `UXCB_OFF_4) rd_val = {modem_control_reg[7:5], loop_reg, modem_control_reg[3:0]};
          if (io_addr == `UXCB_OFF_6) rd_val = ms_block ? `UXCB_STATUS_IR_FIXED : {ms_reg, 4'h0};
        end
        UXCB_BANK1: begin
          if (io_addr == `UXCB_OFF_0) rd_val = scratch_mode ? scr_lo_reg : div_reg[7:0];
          if (io_addr == `UXCB_OFF_1) rd_val = scratch_mode ? scr_hi_reg : div_reg[15:8];
        end
        UXCB_BANK2: begin
          if (io_addr == `UXCB_OFF_0) rd_val = div_reg[7:0];
          if (io_addr == `UXCB_OFF_1) rd_val = div_reg[15:8];
          if (io_addr == `UXCB_OFF_2) rd_val = {extended_control_one[7:5], loop_reg, extended_control_one[3:0]};
          if (io_addr == `UXCB_OFF_4) rd_val = extended_control_two;
          if (io_addr == `UXCB_OFF_6) rd_val = {3'h0, tx_level};
          if (io_addr == `UXCB_OFF_7) rd_val = {3'h0, rx_level};
        end
        UXCB_BANK3: begin
          if (io_addr == `UXCB_OFF_0) rd_val = {MODULE_TYPE, MODULE_REV};
          if (io_addr == `UXCB_OFF_1) rd_val = line_ctrl_reg;
          if (io_addr == `UXCB_OFF_2) rd_val = fifo_ctrl_reg;
        end
        UXCB_BANK4: begin
          if (io_addr == `UXCB_OFF_2) rd_val = infrared_control_one;
        end
        UXCB_BANK5: begin
          if (io_addr == `UXCB_OFF_4) rd_val = infrared_control_two;
        end
        default: rd_val = 8'h00;
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) io_rdata <= 8'h00;
    else if (io_rd) io_rdata <= rd_val;
  end

  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_ctl1_write;
    wr && bank_reg == UXCB_BANK2 && io_addr == `UXCB_OFF_2 && !fallback;
  endsequence
  sequence s_legacy_hit;
    acc && legacy_div && !scratch_mode && extended_select;
  endsequence
  a_ext_select_set: assert property (s_ctl1_write |=> extended_select == $past(io_wdata[0]))
    else $error("extended select did not follow write");
  a_fair_burst_cap: assert property (burst_cnt_reg < 8'(FAIR_CYC))
    else $error("DMA burst ran past its limit");
  a_fair_tx_hold: assert property (dma_fairness_ctl && tx_req_reg && !tx_full && $stable(dma_fairness_ctl)
    |=> tx_req_reg)
    else $error("transmit request dropped before full");
  a_tx_thresh_req: assert property (tx_level < tx_thr && !tx_full && !burst_end |=> tx_req_reg)
    else $error("transmit request missing below threshold");
  a_swap_route_map: assert property (dma_req_a == (dma_channel_swap ? rx_req_reg : tx_req_reg))
    else $error("DMA request routing wrong");
  a_wrap_tx_idle: assert property (wrap_idle [*2] |-> ser_tx_pin && !ir_tx_pin)
    else $error("outputs not idle in loopback");
  a_baud_test_pin: assert property (baud_gen_test_out |-> dtr_pin_n == baud_clk_out)
    else $error("baud clock not on DTR pin");
  a_fallback_clear: assert property (s_legacy_hit |=> !extended_select && !baud_gen_test_out)
    else $error("fallback did not clear extended bits");
  a_status_fixed_val: assert property (io_rd && !dma_cyc && bank_reg == UXCB_BANK0 && io_addr == `UXCB_OFF_6
    && ms_block |=> io_rdata == `UXCB_STATUS_IR_FIXED)
    else $error("status not fixed in infrared mode");
  a_rx_level_read: assert property (rd && bank_reg == UXCB_BANK2 && io_addr == `UXCB_OFF_7
    |=> io_rdata == {3'h0, $past(rx_level)})
    else $error("receive level read wrong");
  a_loop_status_map: assert property (loop_reg && extended_select |=> ms_reg == {$past(modem_control_reg[1]),
    $past(modem_control_reg[0]), $past(modem_control_reg[0]), $past(modem_control_reg[1])})
    else $error("extended loopback status mapping wrong");
endmodule : uxcb_top
`default_nettype wire

// [tb/uxcb_serial_model.sv]
/*
 Model of the serial shifters on the far side of the byte FIFOs.
 Assumes ref_clk timing and valid/ready handshakes.
*/
`timescale 1ns/1ps
`default_nettype none
module uxcb_serial_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [4:0] target,
  input wire logic drain,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  input wire logic rx_byte_ready,
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_valid,
  output logic tx_byte_ready,
  output logic [4:0] sent
);
  logic [7:0] data_reg;
  int seed = 73853;
  // Offer bytes until target; idle data shows the inverse
  assign rx_byte_valid = (sent != target);
  assign rx_byte = rx_byte_valid ? data_reg : ~data_reg;
  assign tx_byte_ready = drain;
  // Count accepted bytes, new data each handshake
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sent <= 5'h00;
      data_reg <= 8'h5A;
    end else if (rx_byte_valid && rx_byte_ready) begin
      sent <= sent + 5'h01;
      data_reg <= 8'($random(seed));
    end
  end
endmodule : uxcb_serial_model
`default_nettype wire

// [tb/uxcb_top_tb.sv]
/*
 Self-checking bench of the extended control banks.
 Assumes the serial model beside the design; inputs change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module uxcb_top_tb;
  import uxcb_pkg::*;
  localparam logic [3:0] MT = 4'hA; // Arbitrary value
  localparam logic [3:0] MR = 4'h3; // Arbitrary value
  logic ref_clk, sys_rst, io_wr, io_rd, ack_a, ack_b, drain, tx_line, ir_tx_line, bclk, irs;
  logic [2:0] io_addr;
  logic [7:0] io_wdata, io_rdata, rx_byte, tx_byte, lctl, pre, rd_v;
  logic [15:0] bdiv;
  logic [4:0] target, sent;
  logic [3:0] mpins;
  logic req_a, req_b, rxv, rxr, txv, txr, rx_line, ser_tx, ir_tx, dtr_n, mevt, rts_n;
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 73853;
  int n;
  uxcb_top #(.FIFO_DEPTH(8), .MODULE_TYPE(MT), .MODULE_REV(MR)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .dma_req_a(req_a), .dma_req_b(req_b), .dma_ack_a(ack_a), .dma_ack_b(ack_b), .tx_byte(tx_byte),
    .tx_byte_valid(txv), .tx_byte_ready(txr), .rx_byte(rx_byte), .rx_byte_valid(rxv), .rx_byte_ready(rxr),
    .tx_line(tx_line), .ir_tx_line(ir_tx_line), .rx_line(rx_line), .ser_rx_pin(~tx_line), .ir_rx_pin(mpins[0]),
    .ser_tx_pin(ser_tx), .ir_tx_pin(ir_tx), .cts_pin_n(mpins[0]), .dsr_pin_n(mpins[1]), .ri_pin_n(mpins[2]),
    .dcd_pin_n(mpins[3]), .dtr_pin_n(dtr_n), .rts_pin_n(rts_n), .baud_clk_out(bclk), .ext_ir_sel(irs),
    .modem_status_evt(mevt), .baud_divisor(bdiv), .prescale_x8(pre), .line_ctrl_reg(lctl));
  uxcb_serial_model partner (.ref_clk(ref_clk), .sys_rst(sys_rst), .target(target), .drain(drain),
    .rx_byte(rx_byte), .rx_byte_valid(rxv), .rx_byte_ready(rxr), .tx_byte(tx_byte), .tx_byte_valid(txv),
    .tx_byte_ready(txr), .sent(sent));
  // Clock generation, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic step(input int c);
    repeat (c) @(negedge ref_clk);
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge ref_clk);
    io_wr = 1'b0;
  endtask : wr
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge ref_clk);
    io_rd = 1'b0;
    chk(io_rdata, exp);
  endtask : rchk
  // Push bytes into the transmit FIFO under DMA acknowledge
  task automatic dpush(input int k);
    ack_a = 1'b1;
    repeat (k) wr(3'h0, 8'($random(seed)));
    ack_a = 1'b0;
  endtask : dpush
  function automatic logic [7:0] pre_exp(input logic [1:0] c, input logic [7:0] prev);
    return c == 2'b00 ? 8'h68 : c == 2'b01 ? 8'h0D : c == 2'b11 ? 8'h08 : prev;
  endfunction : pre_exp
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // Watchdog
  initial begin
    #(100 * 5000);
    n_mismatch++;
    final_report();
  end
  // Main sequence
  initial begin
    {sys_rst, io_wr, io_rd, ack_a, ack_b, drain, tx_line, ir_tx_line, bclk, irs} = 10'h200;
    {io_addr, io_wdata, target} = 16'h0000;
    mpins = 4'($random(seed));
    step(8);
    sys_rst = 1'b0;
    wr(3'h3, 8'hE4);
    rchk(3'h0, {MT, MR});
    rchk(3'h5, 8'h00);
    wr(3'h3, 8'hE0);
    rchk(3'h4, 8'h00);
    wr(3'h2, 8'h43);
    $display("test registers done");
    n = 1 + ($unsigned($random(seed)) % 7);
    dpush(n);
    rchk(3'h6, 8'(n));
    chk(8'(req_a), 8'h01);
    dpush(8 - n);
    step(2);
    chk(8'(req_a), 8'h00);
    target = 5'h03;
    step(6);
    rchk(3'h7, 8'h03);
    chk(8'(req_b), 8'h00);
    target = 5'h04;
    step(4);
    chk(8'(req_b), 8'h01);
    wr(3'h2, 8'h4B);
    step(2);
    chk({req_a, req_b}, 8'h02);
    $display("test dma done");
    for (int c = 0; c < 4; c++) begin
      rd_v = pre;
      wr(3'h4, {2'b00, 2'(c), 4'h0});
      step(1);
      chk(pre, pre_exp(2'(c), rd_v));
    end
    wr(3'h2, 8'h51);
    ir_tx_line = 1'b1;
    step(3);
    chk({ser_tx, ir_tx, rx_line}, 8'h04);
    wr(3'h2, 8'h71);
    step(3);
    chk({ser_tx, ir_tx}, 8'h01);
    wr(3'h2, 8'hC1);
    repeat (2) begin
      bclk = ~bclk;
      step(1);
      chk(8'(dtr_n), 8'(bclk));
    end
    $display("test pins done");
    wr(3'h3, 8'h1B);
    chk(lctl, 8'h1B);
    wr(3'h2, 8'h81);
    wr(3'h3, 8'hE4);
    rchk(3'h1, 8'h1B);
    rchk(3'h2, 8'h81);
    drain = 1'b1;
    step(12);
    wr(3'h3, 8'hE0);
    chk(8'(txv), 8'h00);
    repeat (3) rchk(3'h6, 8'h00);
    $display("test shadows done");
    // Extended loopback status, infrared fixed status, receive timeout, fallback, lock
    wr(3'h2, 8'h51);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h08);
    wr(3'h4, 8'h02);
    step(1);
    chk(8'(mevt), 8'h01);
    chk(8'(rts_n), 8'h00);
    rchk(3'h6, 8'h90);
    irs = 1'b1;
    rchk(3'h6, 8'h30);
    irs = 1'b0;
    drain = 1'b0;
    dpush(8);
    rchk(3'h0, 8'h5A);
    step(300);
    chk(8'(req_b), 8'h00);
    step(105);
    chk(8'(req_b), 8'h01);
    wr(3'h3, 8'h80);
    rchk(3'h0, 8'h01);
    wr(3'h3, 8'hE0);
    rchk(3'h2, 8'h40);
    wr(3'h4, 8'h80);
    wr(3'h3, 8'h80);
    wr(3'h1, 8'hA5);
    rchk(3'h1, 8'hA5);
    chk(bdiv[15:8], 8'h00);
    $display("test status done");
    final_report();
  end
endmodule : uxcb_top_tb
`default_nettype wire
